// ==== src/vsw_pkg.sv ====
/*
  package for the vco subsystem indirect write block: register offsets,
  field positions, reset values and the divider bypass ratio code.
  assumes the serial framing outside delivers whole pll register writes.
*/
package vsw_pkg;
  // -------------------------------------------------------------------
  // pll register offsets
  // -------------------------------------------------------------------
  localparam logic [4:0] PLL_INT_REG = 5'h03;
  localparam logic [4:0] PLL_FRAC_REG = 5'h04;
  localparam logic [4:0] SUBSYS_PORT_REG = 5'h05;
  // -------------------------------------------------------------------
  // vco register addresses and word fields
  // -------------------------------------------------------------------
  localparam logic [3:0] VCO_TUNE_ADDR = 4'h0;
  localparam logic [3:0] VCO_PWR_ADDR = 4'h1;
  localparam logic [3:0] VCO_DIV_ADDR = 4'h2;
  localparam logic [2:0] VCO_SUBSYS_ID = 3'h0;
  localparam int ID_LSB = 0;
  localparam int ID_MSB = 2;
  localparam int ADDR_LSB = 3;
  localparam int ADDR_MSB = 6;
  localparam int DATA_LSB = 7;
  localparam int DATA_W = 9;
  localparam int WORD_W = 16;
  // -------------------------------------------------------------------
  // reset values of the vco registers (power-up content)
  // -------------------------------------------------------------------
  localparam logic [8:0] TUNE_RESET = 9'h020;
  localparam logic [8:0] PWR_RESET = 9'h000;
  localparam logic [8:0] DIV_RESET = 9'h000;
  localparam logic [2:0] RATIO_BYPASS = 3'h7;
endpackage : vsw_pkg

// ==== src/vsw_ratio_decode.sv ====
/*
  turns the three-bit divided output ratio code into a divisor.
  assumes the caller gates the result with the divider enable.
*/
`timescale 1ns/1ps
`default_nettype none
module vsw_ratio_decode (
  input wire logic [2:0] divided_output_ratio,
  output logic [7:0] divisor
);
  // ---------------------------------------------------------------------
  // code 0 is /128 and each step halves it, code 7 is bypass
  // ---------------------------------------------------------------------
  always_comb begin
    divisor = 8'h80 >> divided_output_ratio;
  end
endmodule : vsw_ratio_decode
`default_nettype wire

// ==== src/vsw_indirect_write.sv ====
/*
  vco subsystem indirect write port: decodes pll register writes, routes
  port words into the write-only vco registers and starts the frequency
  update when the closing pll register is written.
  assumes a serial front end on ref_clk gives one-cycle write strobes.
*/
// Functional notes
// - word bits 2:0 hold target id; zero addresses the vco subsystem.
// - word bits 6:3 hold the four-bit vco register address.
// - power register fields: rf power 8:7, bias 11:9, div power 13:12, enable 15.
// - divider register data one at bit 7 selects divide by 64.
// - tuning register word bit 7 selects tune source; zero means manual band.
// - tuning word bits 15:8 carry the band index.
// - frequency update with autocalibration starts on the closing pll write only.
// - tune source zero is internal voltage, one external pin; band 0 highest.
// - ratio codes 0..7 divide by 128 down to bypass, only when enabled.
// - clearing divider enable powers down divider and its buffer.
// - vco registers are write-only, nothing reads them back.
`timescale 1ns/1ps
`default_nettype none
module vsw_indirect_write (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic wr_strobe,
  input wire logic [4:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic frac_mode,
  output logic tune_source_select,
  output logic [7:0] band_index,
  output logic [1:0] main_output_power_level,
  output logic [2:0] oscillator_bias_level,
  output logic [1:0] divided_output_power_level,
  output logic divider_enable,
  output logic divided_output_enable,
  output logic [7:0] divided_output_divisor,
  output logic cal_armed,
  output logic freq_update_start
);
  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [8:0] tune;
    logic [8:0] pwr;
    logic [8:0] div;
    logic armed;
    logic start;
    logic [7:0] divisor;
    logic div_out_en;
  } vsw_state_s;

  vsw_state_s st_reg;
  vsw_state_s st_next;
  logic [7:0] dec_divisor;
  logic [2:0] word_id;
  logic [3:0] word_addr;
  logic [8:0] word_data;
  logic port_hit;
  logic close_hit;
  logic div_load;
  logic [2:0] ratio_next;

  assign word_id = wr_data[vsw_pkg::ID_MSB:vsw_pkg::ID_LSB];
  assign word_addr = wr_data[vsw_pkg::ADDR_MSB:vsw_pkg::ADDR_LSB];
  assign word_data = wr_data[vsw_pkg::DATA_LSB +: vsw_pkg::DATA_W];
  assign port_hit = wr_strobe && (wr_addr == vsw_pkg::SUBSYS_PORT_REG);
  // the closing register depends on integer or fractional mode
  assign close_hit = wr_strobe && (frac_mode ? (wr_addr == vsw_pkg::PLL_FRAC_REG)
                                             : (wr_addr == vsw_pkg::PLL_INT_REG));
  // decode the ratio about to be stored, so the divisor never lags the field
  assign div_load = port_hit && (word_id == vsw_pkg::VCO_SUBSYS_ID)
                    && (word_addr == vsw_pkg::VCO_DIV_ADDR);
  assign ratio_next = div_load ? word_data[2:0] : st_reg.div[2:0];

  vsw_ratio_decode u_dec (
    .divided_output_ratio(ratio_next),
    .divisor(dec_divisor)
  );

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.start = 1'b0;
    if (port_hit) begin
      // the all-zero word arms calibration and, being id zero, still clears tuning
      if (wr_data == 16'h0000) begin
        st_next.armed = 1'b1;
      end
      if (word_id == vsw_pkg::VCO_SUBSYS_ID) begin
        case (word_addr)
          vsw_pkg::VCO_TUNE_ADDR: st_next.tune = word_data;
          vsw_pkg::VCO_PWR_ADDR: st_next.pwr = word_data;
          vsw_pkg::VCO_DIV_ADDR: st_next.div = word_data;
          default: st_next.tune = st_reg.tune;
        endcase
      end
    end
    if (close_hit) begin
      // the update fires only on the closing write, never earlier
      st_next.start = 1'b1;
      st_next.armed = 1'b0;
    end
    st_next.div_out_en = st_next.pwr[8];
    // a disabled divider shows divisor zero: no output at all
    st_next.divisor = st_next.pwr[8] ? dec_divisor : 8'h00;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_reg <= '{tune: vsw_pkg::TUNE_RESET, pwr: vsw_pkg::PWR_RESET,
                  div: vsw_pkg::DIV_RESET, armed: 1'b0, start: 1'b0,
                  divisor: 8'h00, div_out_en: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------------
  // outputs; no read path exists, registers are write-only
  // ---------------------------------------------------------------------
  assign tune_source_select = st_reg.tune[0];
  assign band_index = st_reg.tune[8:1];
  assign main_output_power_level = st_reg.pwr[1:0];
  assign oscillator_bias_level = st_reg.pwr[4:2];
  assign divided_output_power_level = st_reg.pwr[6:5];
  assign divider_enable = st_reg.pwr[8];
  assign divided_output_enable = st_reg.div_out_en;
  assign divided_output_divisor = st_reg.divisor;
  assign cal_armed = st_reg.armed;
  assign freq_update_start = st_reg.start;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  a_port_load_div: assert property (@(posedge ref_clk) disable iff (reset)
    port_hit && wr_data[6:0] == 7'h10 |=> st_reg.div == $past(wr_data[15:7]))
    else $error("divider register not loaded");
  a_pwr_fields: assert property (@(posedge ref_clk) disable iff (reset)
    port_hit && wr_data[6:0] == 7'h08 |=>
      oscillator_bias_level == $past(wr_data[11:9]) &&
      divider_enable == $past(wr_data[15]))
    else $error("power fields misplaced");
  a_power_levels: assert property (@(posedge ref_clk) disable iff (reset)
    port_hit && wr_data[6:0] == 7'h08 |=>
      main_output_power_level == $past(wr_data[8:7]) &&
      divided_output_power_level == $past(wr_data[13:12]))
    else $error("output power levels misplaced");
  a_tune_fields: assert property (@(posedge ref_clk) disable iff (reset)
    port_hit && wr_data[6:0] == 7'h00 |=>
      band_index == $past(wr_data[15:8]) && tune_source_select == $past(wr_data[7]))
    else $error("tuning fields misplaced");
  a_tune_source: assert property (@(posedge ref_clk) disable iff (reset)
    port_hit && wr_data[6:0] == 7'h00 && !wr_data[7] |=> !tune_source_select)
    else $error("manual band write left the tune source external");
  a_zero_word: assert property (@(posedge ref_clk) disable iff (reset)
    port_hit && wr_data == 16'h0000 |=> band_index == 8'h00 && !tune_source_select)
    else $error("zero word did not clear the tuning register");

  // ---------------------------------------------------------------------
  // checks: refused words
  // ---------------------------------------------------------------------
  a_foreign_id: assert property (@(posedge ref_clk) disable iff (reset)
    port_hit && wr_data[2:0] != 3'h0 |=>
      $stable(st_reg.tune) && $stable(st_reg.pwr) && $stable(st_reg.div))
    else $error("foreign subsystem write changed vco state");
  a_foreign_addr: assert property (@(posedge ref_clk) disable iff (reset)
    port_hit && wr_data[2:0] == 3'h0 && wr_data[6:3] > 4'h2 |=>
      $stable(st_reg.tune) && $stable(st_reg.pwr) && $stable(st_reg.div))
    else $error("unknown vco address changed vco state");
  a_other_pll: assert property (@(posedge ref_clk) disable iff (reset)
    wr_strobe && wr_addr != vsw_pkg::SUBSYS_PORT_REG |=>
      $stable(st_reg.tune) && $stable(st_reg.pwr) && $stable(st_reg.div))
    else $error("other pll register changed vco state");

  // ---------------------------------------------------------------------
  // checks: output divider
  // ---------------------------------------------------------------------
  a_div64_code: assert property (@(posedge ref_clk) disable iff (reset)
    divider_enable && st_reg.div[2:0] == 3'h1 |-> divided_output_divisor == 8'h40)
    else $error("code one is not divide by 64");
  a_div128_code: assert property (@(posedge ref_clk) disable iff (reset)
    divider_enable && st_reg.div[2:0] == 3'h0 |-> divided_output_divisor == 8'h80)
    else $error("code zero is not divide by 128");
  a_bypass_code: assert property (@(posedge ref_clk) disable iff (reset)
    divider_enable && st_reg.div[2:0] == vsw_pkg::RATIO_BYPASS |->
      divided_output_divisor == 8'h01)
    else $error("bypass code does not pass the doubled frequency");
  a_div_off: assert property (@(posedge ref_clk) disable iff (reset)
    !divider_enable |-> !divided_output_enable && divided_output_divisor == 8'h00)
    else $error("divider output alive while disabled");
  a_div_on: assert property (@(posedge ref_clk) disable iff (reset)
    divider_enable |-> divided_output_enable && divided_output_divisor != 8'h00)
    else $error("divider output dead while enabled");

  // ---------------------------------------------------------------------
  // checks: frequency update
  // ---------------------------------------------------------------------
  a_start_cause: assert property (@(posedge ref_clk) disable iff (reset)
    freq_update_start |-> $past(close_hit))
    else $error("update started without closing write");
  a_start_pulse: assert property (@(posedge ref_clk) disable iff (reset)
    close_hit |=> freq_update_start ##1 !freq_update_start || $past(close_hit))
    else $error("update start not a pulse");
  a_no_early_start: assert property (@(posedge ref_clk) disable iff (reset)
    wr_strobe && !close_hit |=> !freq_update_start)
    else $error("update started on a write that does not close");
  a_arm_zero: assert property (@(posedge ref_clk) disable iff (reset)
    port_hit && wr_data == 16'h0 && !close_hit |=> cal_armed)
    else $error("zero write did not arm calibration");
  a_arm_hold: assert property (@(posedge ref_clk) disable iff (reset)
    cal_armed && !close_hit |=> cal_armed)
    else $error("calibration arm lost before the closing write");
  a_arm_clear: assert property (@(posedge ref_clk) disable iff (reset)
    close_hit |=> !cal_armed)
    else $error("calibration arm kept after the closing write");
endmodule : vsw_indirect_write
`default_nettype wire

// ==== tb/vsw_host_model.sv ====
/*
  host model: issues whole pll register writes on ref_clk.
  assumes the block takes a write on a rising edge with the strobe high.
*/
`timescale 1ns/1ps
`default_nettype none
module vsw_host (
  input wire logic ref_clk,
  output logic wr_strobe,
  output logic [4:0] wr_addr,
  output logic [15:0] wr_data
);
  initial begin
    wr_strobe = 1'b0;
    wr_addr = 5'h00;
    wr_data = 16'h0000;
  end
  // released lines show the inverse so stale values never look valid
  task automatic put(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    #1;
    wr_strobe = 1'b1;
    wr_addr = a;
    wr_data = d;
    @(posedge ref_clk);
    #1;
    wr_strobe = 1'b0;
    wr_addr = ~a;
    wr_data = ~d;
  endtask : put
endmodule : vsw_host
`default_nettype wire

// ==== tb/testbench.sv ====
/*
  testbench: drives the indirect write block through the host model.
  assumes registered outputs settle within one cycle of a taken write.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic ref_clk, reset, frac_mode, wr_strobe, src, den, dout_en, armed, start;
  logic [4:0] wr_addr;
  logic [15:0] wr_data;
  logic [7:0] band, divisor;
  logic [1:0] mpwr, dpwr;
  logic [2:0] bias;
  int fail_count = 0;
  int samples_checked = 0;
  int starts = 0;
  int s0;
  vsw_host host (.ref_clk(ref_clk), .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data));
  vsw_indirect_write dut (.ref_clk(ref_clk), .reset(reset), .wr_strobe(wr_strobe),
    .wr_addr(wr_addr), .wr_data(wr_data), .frac_mode(frac_mode), .tune_source_select(src),
    .band_index(band), .main_output_power_level(mpwr), .oscillator_bias_level(bias),
    .divided_output_power_level(dpwr), .divider_enable(den), .divided_output_enable(dout_en),
    .divided_output_divisor(divisor), .cal_armed(armed), .freq_update_start(start));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (start === 1'b1) starts++;
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    host.put(a, d);
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : wr
  task automatic final_report();
    if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report
  task automatic t_reset();
    chk("band", 8'h10, band);
    chk("src", 8'h00, {7'h00, src});
    chk("armed", 8'h00, {7'h00, armed});
    chk("divisor", 8'h00, divisor);
  endtask : t_reset
  task automatic t_example();
    wr(5'h05, 16'h0090);
    chk("divisor", 8'h00, divisor);
    wr(5'h05, 16'hBF88);
    chk("divisor", 8'h40, divisor);
    chk("enable", 8'h01, {7'h00, den});
    chk("bias", 8'h07, {5'h00, bias});
    chk("powers", 8'h0F, {4'h0, mpwr, dpwr});
    wr(5'h05, 16'hCD00);
    chk("band", 8'hCD, band);
    chk("src", 8'h00, {7'h00, src});
  endtask : t_example
  task automatic t_refuse();
    wr(5'h05, 16'h1281);
    chk("band", 8'hCD, band);
    wr(5'h05, 16'h1298);
    chk("band", 8'hCD, band);
    wr(5'h05, 16'h1280);
    chk("band", 8'h12, band);
    chk("src", 8'h01, {7'h00, src});
  endtask : t_refuse
  task automatic t_ratio();
    logic [63:0] exp_div;
    exp_div = 64'h8040201008040201;
    for (int i = 0; i < 8; i++) begin
      wr(5'h05, {6'h00, i[2:0], 7'h10});
      chk("divisor", exp_div[63 - 8 * i -: 8], divisor);
    end
    wr(5'h05, 16'h3F88);
    chk("divisor", 8'h00, divisor);
    chk("out_en", 8'h00, {7'h00, dout_en});
  endtask : t_ratio
  task automatic t_update(input logic f, input logic [4:0] close, input logic [4:0] other);
    frac_mode = f;
    wr(5'h05, 16'h0000);
    chk("armed", 8'h01, {7'h00, armed});
    chk("band", 8'h00, band);
    chk("src", 8'h00, {7'h00, src});
    s0 = starts;
    wr(other, 16'h0000);
    chk("starts", 8'h00, 8'(starts - s0));
    wr(close, 16'h0000);
    chk("starts", 8'h01, 8'(starts - s0));
    chk("armed", 8'h00, {7'h00, armed});
  endtask : t_update
  task automatic t_midreset();
    wr(5'h05, 16'h0000);
    wr(5'h05, 16'hBF88);
    @(posedge ref_clk);
    #1;
    reset = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    chk("armed", 8'h00, {7'h00, armed});
    chk("band", 8'h10, band);
    chk("enable", 8'h00, {7'h00, den});
    chk("bias", 8'h00, {5'h00, bias});
    wr(5'h05, 16'h1280);
    chk("band", 8'h12, band);
  endtask : t_midreset
  initial begin
    reset = 1'b1;
    frac_mode = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    t_reset();
    t_example();
    t_refuse();
    t_ratio();
    t_update(1'b0, 5'h03, 5'h04);
    t_update(1'b1, 5'h04, 5'h03);
    t_midreset();
    final_report();
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    fail_count++;
    final_report();
  end
endmodule : testbench
`default_nettype wire
